// >>> rtl/sep_pkg.sv
// Shared constants, types and states of the serial memory target.
// Assumes a single 200 MHz clock; all pins are asynchronous to it.
package sep_pkg;

	// Clock and self-timed programming time
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned SELF_TIMED_PROGRAM_TIME_NS = 5000000; // 5 ms
	// Longest time, so the cycle count rounds down
	localparam int unsigned PROG_CYCLES = SELF_TIMED_PROGRAM_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned PROG_CNT_W = 20;

	// Array geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned MEM_WORDS = 256;
	localparam int unsigned PAGE_LOW_W = 3;
	localparam int unsigned PAGE_BYTES = 8;
	localparam logic [7:0] ADDR_RST = 8'h00;

	// Device address word layout
	localparam logic [3:0] DEV_PREFIX = 4'hA;
	localparam int unsigned DEV_PREFIX_LSB = 4;
	localparam int unsigned DEV_CS_LSB = 1;
	localparam int unsigned DEV_RW_BIT = 0;

	// Write data buffer depth
	localparam int unsigned FIFO_DEPTH = 4;

	// Positions in the synchronised pin bundle
	localparam int unsigned PIN_SCL = 0;
	localparam int unsigned PIN_SDA = 1;
	localparam int unsigned PIN_WP = 2;
	localparam int unsigned PIN_CS_LSB = 3;
	localparam int unsigned PIN_W = 6;

	// One received data byte and the location it goes to
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} sep_wr_word_t;

	// Bus engine states, Gray coded along the write path; ST_ACK_DEV to ST_RDATA is not
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_DEV = 4'h1,
		ST_ACK_DEV = 4'h3,
		ST_WADDR = 4'h2,
		ST_ACK_WA = 4'h6,
		ST_WDATA = 4'h7,
		ST_ACK_WD = 4'h5,
		ST_RDATA = 4'h4,
		ST_RACK = 4'hC
	} sep_state_t;

endpackage : sep_pkg

// >>> rtl/sep_pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; only the second stage is read.
`timescale 1ns/100ps
module sep_pin_sync #(
	parameter int unsigned WIDTH = sep_pkg::PIN_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta;

	// One pair of flops per pin
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				meta[i] <= 1'b1;
				dout[i] <= 1'b1;
			end else begin
				meta[i] <= din[i];
				dout[i] <= meta[i];
			end
		end
	end

endmodule : sep_pin_sync

// >>> rtl/sep_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; full and empty come from wide pointers.
`timescale 1ns/100ps
module sep_fifo #(
	parameter int unsigned WIDTH = $bits(sep_pkg::sep_wr_word_t),
	parameter int unsigned DEPTH = sep_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW:0] wr_ptr;
	logic [PW:0] rd_ptr;

	// Full when pointers differ only in the wrap bit
	assign in_ready = (wr_ptr != {~rd_ptr[PW], rd_ptr[PW-1:0]});
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data = store[rd_ptr[PW-1:0]];

	// Storage has no reset; only pointers define content
	always_ff @(posedge ref_clk) begin
		if (in_valid && in_ready) begin
			store[wr_ptr[PW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule : sep_fifo

// >>> rtl/sep_eeprom.sv
// Two-wire serial memory target: reads, word address counter, polling.
// Assumes scl and sda come straight from pins; sda is open drain and the
// pad resolves the wire from sda_oe_n. No other clock or reset exists.
`timescale 1ns/100ps
module sep_eeprom #(
	parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic write_protect,
	input wire logic chip_select_strap_high,
	input wire logic chip_select_strap_mid,
	input wire logic chip_select_strap_low
);

	logic [sep_pkg::PIN_W-1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] cs_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	sep_pkg::sep_state_t state;
	logic [2:0] bit_cnt;
	logic byte_done;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic ack_pend;
	logic rd_mode;
	logic mack;
	logic [7:0] addr;
	logic [7:0] byte_in;
	logic last_bit;
	logic dev_hit;
	logic ld_rd;
	logic addr_load;
	logic wr_acc;

	logic [7:0] mem [sep_pkg::MEM_WORDS];
	logic [7:0] mem_rd;

	sep_pkg::sep_wr_word_t push_word;
	sep_pkg::sep_wr_word_t pop_word;
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;

	logic [7:0] page_buf [sep_pkg::PAGE_BYTES];
	logic [sep_pkg::PAGE_BYTES-1:0] page_mask;
	logic [4:0] page_row;
	logic wr_flag;
	logic commit_req;
	logic prog_busy;
	logic prog_start;
	logic prog_done;
	logic [sep_pkg::PROG_CNT_W-1:0] prog_cnt;

	// Pins are asynchronous, so all of them pass two flops first
	sep_pin_sync #(
		.WIDTH(sep_pkg::PIN_W)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din({chip_select_strap_high, chip_select_strap_mid, chip_select_strap_low,
			write_protect, sda_i, scl_i}),
		.dout(pins_s)
	);

	assign scl_s = pins_s[sep_pkg::PIN_SCL];
	assign sda_s = pins_s[sep_pkg::PIN_SDA];
	assign wp_s = pins_s[sep_pkg::PIN_WP];
	assign cs_s = pins_s[sep_pkg::PIN_CS_LSB +: 3];

	// Open drain: the pad only ever pulls low
	assign sda_o = 1'b0;

	// Previous synced levels for edge and condition detection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Edges of the bus clock; start and stop are data moves while it is high
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det = scl_s && scl_q && !sda_q && sda_s;

	// Byte assembly and address decode
	assign byte_in = {shreg[6:0], sda_s};
	assign last_bit = scl_rise && (bit_cnt == 3'h7);
	assign dev_hit = (byte_in[7:sep_pkg::DEV_PREFIX_LSB] == sep_pkg::DEV_PREFIX)
		&& (byte_in[sep_pkg::DEV_CS_LSB +: 3] == cs_s);
	assign mem_rd = mem[addr];

	// Load of a read byte: after the address acknowledge or a controller acknowledge
	assign ld_rd = scl_fall && (((state == sep_pkg::ST_ACK_DEV) && rd_mode)
		|| ((state == sep_pkg::ST_RACK) && mack));
	assign addr_load = last_bit && (state == sep_pkg::ST_WADDR);
	assign push_valid = last_bit && (state == sep_pkg::ST_WDATA);
	assign wr_acc = push_valid && push_ready;
	assign push_word = '{addr: addr, data: byte_in};

	// Bus engine: starts win over everything, stops next, then clock edges
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= sep_pkg::ST_IDLE;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			shreg <= 8'h00;
			tx <= 8'h00;
			ack_pend <= 1'b0;
			rd_mode <= 1'b0;
			mack <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (start_det) begin
			// A busy device ignores the bus, so polling sees no acknowledge
			state <= prog_busy ? sep_pkg::ST_IDLE : sep_pkg::ST_DEV;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (stop_det) begin
			state <= sep_pkg::ST_IDLE;
			byte_done <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (scl_rise) begin
			unique case (state)
				sep_pkg::ST_DEV, sep_pkg::ST_WADDR, sep_pkg::ST_WDATA: begin
					shreg <= byte_in;
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						byte_done <= 1'b1;
						if (state == sep_pkg::ST_DEV) begin
							ack_pend <= dev_hit;
							rd_mode <= byte_in[sep_pkg::DEV_RW_BIT];
						end else if (state == sep_pkg::ST_WDATA) begin
							// A full buffer cannot take the byte, so it is refused
							ack_pend <= push_ready;
						end else begin
							ack_pend <= 1'b1;
						end
					end
				end
				sep_pkg::ST_RDATA: begin
					bit_cnt <= bit_cnt + 3'h1;
					byte_done <= (bit_cnt == 3'h7);
				end
				sep_pkg::ST_RACK: begin
					mack <= !sda_s;
				end
				sep_pkg::ST_IDLE, sep_pkg::ST_ACK_DEV, sep_pkg::ST_ACK_WA,
				sep_pkg::ST_ACK_WD: begin
					bit_cnt <= bit_cnt;
				end
			endcase
		end else if (scl_fall) begin
			unique case (state)
				sep_pkg::ST_DEV, sep_pkg::ST_WADDR, sep_pkg::ST_WDATA: begin
					if (byte_done) begin
						byte_done <= 1'b0;
						// Pull low through the ninth clock to acknowledge
						sda_oe_n <= !ack_pend;
						if (!ack_pend) begin
							state <= sep_pkg::ST_IDLE;
						end else if (state == sep_pkg::ST_DEV) begin
							state <= sep_pkg::ST_ACK_DEV;
						end else if (state == sep_pkg::ST_WADDR) begin
							state <= sep_pkg::ST_ACK_WA;
						end else begin
							state <= sep_pkg::ST_ACK_WD;
						end
					end
				end
				sep_pkg::ST_ACK_DEV: begin
					bit_cnt <= 3'h0;
					if (rd_mode) begin
						// First data bit goes out right after the acknowledge
						state <= sep_pkg::ST_RDATA;
						sda_oe_n <= mem_rd[7];
						tx <= {mem_rd[6:0], 1'b0};
					end else begin
						state <= sep_pkg::ST_WADDR;
						sda_oe_n <= 1'b1;
					end
				end
				sep_pkg::ST_ACK_WA, sep_pkg::ST_ACK_WD: begin
					state <= sep_pkg::ST_WDATA;
					bit_cnt <= 3'h0;
					sda_oe_n <= 1'b1;
				end
				sep_pkg::ST_RDATA: begin
					if (byte_done) begin
						// Let the controller own the acknowledge slot
						byte_done <= 1'b0;
						state <= sep_pkg::ST_RACK;
						sda_oe_n <= 1'b1;
					end else begin
						sda_oe_n <= tx[7];
						tx <= {tx[6:0], 1'b0};
					end
				end
				sep_pkg::ST_RACK: begin
					bit_cnt <= 3'h0;
					if (mack) begin
						state <= sep_pkg::ST_RDATA;
						sda_oe_n <= mem_rd[7];
						tx <= {mem_rd[6:0], 1'b0};
					end else begin
						// No acknowledge: stay released until the next start or stop
						state <= sep_pkg::ST_IDLE;
					end
				end
				sep_pkg::ST_IDLE: begin
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// Word address counter; nothing but accesses move it, stops keep it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addr <= sep_pkg::ADDR_RST;
		end else if (addr_load) begin
			addr <= byte_in;
		end else if (ld_rd) begin
			// Natural 8-bit wrap runs from the last page to the first
			addr <= addr + 8'h01;
		end else if (wr_acc) begin
			addr <= {addr[7:3], addr[2:0] + 3'h1};
		end
	end

	// Received data waits here until it reaches the page latch
	sep_fifo #(
		.WIDTH($bits(sep_pkg::sep_wr_word_t)),
		.DEPTH(sep_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_word)
	);

	// The latch is frozen while the array is being programmed
	assign pop_ready = !prog_busy;

	// Page latch slots, one per byte of a page
	for (genvar i = 0; i < sep_pkg::PAGE_BYTES; i++) begin : g_slot
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				page_buf[i] <= 8'h00;
				page_mask[i] <= 1'b0;
			end else if (pop_valid && pop_ready && (pop_word.addr[2:0] == 3'(i))) begin
				page_buf[i] <= pop_word.data;
				page_mask[i] <= 1'b1;
			end else if (prog_done || (prog_start && wp_s)) begin
				page_mask[i] <= 1'b0;
			end
		end
	end

	// Page row follows the latched bytes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			page_row <= 5'h00;
		end else if (pop_valid && pop_ready) begin
			page_row <= pop_word.addr[7:3];
		end
	end

	// A stop after accepted data asks for programming once the buffer drains
	assign prog_start = commit_req && !pop_valid;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_flag <= 1'b0;
			commit_req <= 1'b0;
		end else begin
			if (stop_det) begin
				wr_flag <= 1'b0;
			end else if (wr_acc) begin
				wr_flag <= 1'b1;
			end
			if (stop_det && (wr_flag || wr_acc)) begin
				commit_req <= 1'b1;
			end else if (prog_start) begin
				commit_req <= 1'b0;
			end
		end
	end

	// Self-timed programming; protection drops the page without a cycle
	localparam int unsigned PROG_CNT_W = sep_pkg::PROG_CNT_W;
	assign prog_done = prog_busy && (prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prog_busy <= 1'b0;
			prog_cnt <= '0;
		end else if (prog_start && !wp_s && (page_mask != '0)) begin
			prog_busy <= 1'b1;
			prog_cnt <= '0;
		end else if (prog_done) begin
			prog_busy <= 1'b0;
		end else if (prog_busy) begin
			prog_cnt <= prog_cnt + 1'b1;
		end
	end

	// Array update at the end of the cycle; no reset on storage
	always_ff @(posedge ref_clk) begin
		if (prog_done) begin
			for (int k = 0; k < sep_pkg::PAGE_BYTES; k++) begin
				if (page_mask[k]) begin
					mem[{page_row, 3'(k)}] <= page_buf[k];
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_read_load;
		ld_rd;
	endsequence

	sequence s_drive_msb;
		##1 (sda_oe_n == $past(mem_rd[7]));
	endsequence

	chk_busy_no_ack: assert property (prog_busy |-> (state != sep_pkg::ST_ACK_DEV))
		else $error("address acknowledged during programming");
	chk_wp_blocks: assert property ((prog_start && wp_s) |=> !prog_busy)
		else $error("programming started while protected");
	chk_addr_keep: assert property (stop_det |=> $stable(addr))
		else $error("word address changed at stop");
	chk_read_wrap: assert property ((ld_rd && (addr == 8'hFF)) |=> (addr == 8'h00))
		else $error("read address did not wrap to zero");
	chk_write_wrap: assert property (wr_acc |=> ((addr[7:3] == $past(addr[7:3]))
		&& (addr[2:0] == $past(addr[2:0]) + 3'h1)))
		else $error("write address left its page");
	chk_msb_first: assert property (s_read_load |-> s_drive_msb)
		else $error("first read bit is not the byte msb");
	chk_rd_incr: assert property (ld_rd |=> (addr == $past(addr) + 8'h01))
		else $error("read did not advance word address");
	chk_stop_release: assert property (stop_det |=> sda_oe_n)
		else $error("data line held after stop");
	chk_ack_slot: assert property ((state == sep_pkg::ST_RACK) |-> sda_oe_n)
		else $error("data line driven in controller ack slot");
	chk_dev_match: assert property ((state == sep_pkg::ST_DEV) && last_bit && !dev_hit
		|=> !ack_pend)
		else $error("acknowledge pending for foreign address");
	chk_ack_low: assert property ($rose(state == sep_pkg::ST_ACK_WA) |-> !sda_oe_n)
		else $error("word address not acknowledged low");
	chk_busy_ignore: assert property ((prog_busy && start_det) |=>
		(state == sep_pkg::ST_IDLE)[*2])
		else $error("bus answered during programming");

endmodule : sep_eeprom

// >>> tb/sep_ctrl_model.sv
// Behavioural two-wire bus controller driving the serial memory target.
// Assumes a pull-up on the data wire; the clock stands high between frames.
`timescale 1ns/100ps
module sep_ctrl_model (
	output logic scl,
	output logic sda_pull,
	input wire logic sda_wire
);
	// 48 ns link clock; data moves a quarter period after each fall
	localparam time QTR = 12ns;
	localparam time HALF = 24ns;

	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Data falls while the clock is high; also serves as repeated start
	task automatic start_cond();
		sda_pull = 1'b0;
		#QTR;
		scl = 1'b1;
		#HALF;
		sda_pull = 1'b1;
		#HALF;
		scl = 1'b0;
		#QTR;
	endtask : start_cond

	// One clock; wire sampled just before the fall, after target data settled
	task automatic clk_bit(input logic drive_low, output logic seen);
		sda_pull = drive_low;
		#QTR;
		scl = 1'b1;
		#HALF;
		seen = sda_wire;
		scl = 1'b0;
		#QTR;
	endtask : clk_bit

	// Data rises while the clock is high; bus left idle
	task automatic stop_cond();
		sda_pull = 1'b1;
		#QTR;
		scl = 1'b1;
		#HALF;
		sda_pull = 1'b0;
		#HALF;
	endtask : stop_cond

	// Byte out, most significant bit first; returns the acknowledge level
	task automatic send_byte(input logic [7:0] b, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(~b[i], s);
		end
		clk_bit(1'b0, nak);
	endtask : send_byte

	// Byte in; ack_it pulls the ninth bit low, slot is the wire seen there
	task automatic recv_byte(input logic ack_it, output logic [7:0] b, output logic slot);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b0, b[i]);
		end
		clk_bit(ack_it, slot);
	endtask : recv_byte

endmodule : sep_ctrl_model

// >>> tb/serial_eeprom_read_and_poll_bench.sv
// Self-checking bench: writes, polling, reads and wrap of the serial target.
// Assumes the controller model owns the link; the receive buffer is reached via the bus.
`timescale 1ns/100ps
module serial_eeprom_read_and_poll_bench;
	localparam int unsigned PROG = 200;
	localparam logic [2:0] STRAPS = 3'h5;
	logic ref_clk, rst, wp, sda_o, sda_oe_n, scl, sda_pull, sda_wire;
	logic [2:0] straps;
	logic [7:0] exp_mem [256];
	int errors, n_compared;

	// Open-drain wire with pull-up: low when either party pulls
	assign sda_wire = ~(sda_pull | (~sda_oe_n & ~sda_o));

	// Short programming time keeps polling scenarios brief
	sep_eeprom #(.PROG_CYCLES(PROG)) u_sep_eeprom (.ref_clk(ref_clk), .rst(rst), .scl_i(scl),
		.sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_protect(wp),
		.chip_select_strap_high(straps[2]), .chip_select_strap_mid(straps[1]),
		.chip_select_strap_low(straps[0]));
	sep_ctrl_model u_sep_ctrl_model (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	function automatic logic [7:0] dev(input logic [2:0] cs, input logic rw);
		return {sep_pkg::DEV_PREFIX, cs, rw};
	endfunction : dev

	task automatic addr_phase(input logic rw, output logic nak);
		u_sep_ctrl_model.start_cond();
		u_sep_ctrl_model.send_byte(dev(STRAPS, rw), nak);
	endtask : addr_phase

	// Page write of n bytes from a; byte i carries seed+i
	task automatic page_write(input logic [7:0] a, input int n, input logic [7:0] seed);
		logic nak;
		addr_phase(1'b0, nak);
		check("write addr ack", 8'(nak), 8'h00);
		u_sep_ctrl_model.send_byte(a, nak);
		check("word addr ack", 8'(nak), 8'h00);
		for (int i = 0; i < n; i++) begin
			u_sep_ctrl_model.send_byte(seed + 8'(i), nak);
			check("data ack", 8'(nak), 8'h00);
			if (!wp) exp_mem[{a[7:3], 3'(a[2:0] + 3'(i))}] = seed + 8'(i);
		end
		u_sep_ctrl_model.stop_cond();
	endtask : page_write

	// Polls with write direction until answered; counts refusals, bounded
	task automatic poll(output int refused);
		logic nak;
		refused = 0;
		nak = 1'b1;
		while (nak && refused < 8) begin
			addr_phase(1'b0, nak);
			u_sep_ctrl_model.stop_cond();
			if (nak) refused++;
		end
	endtask : poll

	// Reads n bytes expecting a upward with full wrap, last one refused
	task automatic read_run(input logic [7:0] a, input int n);
		logic [7:0] b;
		logic slot;
		for (int i = 0; i < n; i++) begin
			u_sep_ctrl_model.recv_byte(i != n - 1, b, slot);
			check("read data", b, exp_mem[a + 8'(i)]);
		end
		check("nak slot released", 8'(slot), 8'h01);
		check("line after nak", 8'(sda_oe_n), 8'h01);
		u_sep_ctrl_model.stop_cond();
		check("line after stop", 8'(sda_oe_n), 8'h01);
	endtask : read_run

	task automatic random_read(input logic [7:0] a, input int n);
		logic nak;
		addr_phase(1'b0, nak);
		u_sep_ctrl_model.send_byte(a, nak);
		check("dummy addr ack", 8'(nak), 8'h00);
		addr_phase(1'b1, nak);
		check("read addr ack", 8'(nak), 8'h00);
		read_run(a, n);
	endtask : random_read

	task automatic current_read(input logic [7:0] a, input int n);
		logic nak;
		addr_phase(1'b1, nak);
		check("current addr ack", 8'(nak), 8'h00);
		read_run(a, n);
	endtask : current_read

	// Ten bytes into one page wrap and overwrite; busy refuses polls
	task automatic t_page_wrap();
		int r;
		page_write(8'h3E, 10, 8'h50);
		poll(r);
		check("poll refused first", 8'(r >= 1), 8'h01);
		check("poll answered", 8'(r < 8), 8'h01);
		random_read(8'h38, 5);
		repeat (50) @(posedge ref_clk);
		current_read(8'h3D, 3);
	endtask : t_page_wrap

	// Reads across the top of the array
	task automatic t_top_wrap();
		int r;
		page_write(8'hFF, 2, 8'hA0);
		poll(r);
		page_write(8'h00, 1, 8'hC3);
		poll(r);
		random_read(8'hFF, 2);
		random_read(8'hF8, 1);
	endtask : t_top_wrap

	// Protected write leaves the array and starts no busy period
	task automatic t_protect();
		int r;
		@(posedge ref_clk);
		wp <= 1'b1;
		@(posedge ref_clk);
		page_write(8'h38, 1, 8'h11);
		poll(r);
		check("protected no busy", 8'(r), 8'h00);
		@(posedge ref_clk);
		wp <= 1'b0;
		random_read(8'h38, 1);
	endtask : t_protect

	// Foreign addresses get no answer and no data
	task automatic t_mismatch();
		logic [7:0] bad [4];
		logic [7:0] b;
		logic nak;
		bad = '{dev(STRAPS ^ 3'h1, 1'b1), dev(STRAPS ^ 3'h2, 1'b1), dev(STRAPS ^ 3'h4, 1'b1),
			{4'hB, STRAPS, 1'b1}};
		for (int k = 0; k < 4; k++) begin
			u_sep_ctrl_model.start_cond();
			u_sep_ctrl_model.send_byte(bad[k], nak);
			check("foreign addr nak", 8'(nak), 8'h01);
			u_sep_ctrl_model.recv_byte(1'b0, b, nak);
			check("foreign idle line", b, 8'hFF);
			u_sep_ctrl_model.stop_cond();
		end
	endtask : t_mismatch

	// Four bytes pass the receive buffer into the array; drain shows as a busy period
	task automatic t_fifo();
		int r;
		page_write(8'h10, 4, 8'h70);
		poll(r);
		check("fifo accepted", 8'(r < 8), 8'h01);
		check("fifo drained", 8'(r >= 1), 8'h01);
		random_read(8'h10, 4);
		check("open drain value", 8'(sda_o), 8'h00);
	endtask : t_fifo

	initial begin
		errors = 0;
		n_compared = 0;
		rst = 1'b1;
		wp = 1'b0;
		straps = STRAPS;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		t_fifo();
		t_page_wrap();
		t_top_wrap();
		t_protect();
		t_mismatch();
		end_sim();
	end

	// Watchdog: the tests need some tens of microseconds
	initial begin
		#200us;
		errors++;
		$display("CHECK FAILED watchdog expected done seen hang");
		end_sim();
	end

endmodule : serial_eeprom_read_and_poll_bench
